//--- design/disp_pkg.sv
// Package with shared constants and a carrier type for the serial display driver.
package disp_pkg;
  localparam int STAGES      = 32;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_STAGES = 2;

  // One sampled set of the pin inputs, carried as a unit through the FIFO.
  typedef struct packed {
    logic data;
    logic cs;
    logic gate;
    logic invert;
    logic sclk;
  } pin_sample_type;

  localparam int SAMPLE_W = $bits(pin_sample_type);
endpackage

//--- design/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- design/sample_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- design/serial_display_driver.sv
// Serial-in, parallel-out 32-stage display driver sampled on the system clock.
`timescale 1ns/10ps
module serial_display_driver #(
  parameter int STAGES = disp_pkg::STAGES,
  parameter int DEPTH  = disp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Pins from the host or upstream driver
  input  wire logic              shift_clk,
  input  wire logic              serial_in,
  input  wire logic              chip_select,
  input  wire logic              gate,
  input  wire logic              invert,
  // Drive outputs
  output logic      [STAGES-1:0] drive_out,
  output logic                   serial_out,
  output logic                   contents_valid,
  output logic                   sample_overflow
);
  localparam int W = disp_pkg::SAMPLE_W;

  disp_pkg::pin_sample_type raw;
  disp_pkg::pin_sample_type synced;
  disp_pkg::pin_sample_type head;
  logic [W-1:0]             head_bits;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     prev_sclk;
  logic [STAGES-1:0]        stage_bits;
  logic [$clog2(STAGES):0]  fill_count;
  logic                     cur_cs;
  logic                     cur_gate;
  logic                     cur_inv;
  logic                     shift_edge;

  assign raw.data   = serial_in;
  assign raw.cs     = chip_select;
  assign raw.gate   = gate;
  assign raw.invert = invert;
  assign raw.sclk   = shift_clk;

  pin_sync #(
    .WIDTH (W)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (raw),
    .sync_out (synced)
  );

  // The FIFO is drained every cycle, so it never backs up in practice; it
  // keeps the pin samples in order and reports any loss of a sample.
  sample_fifo #(
    .WIDTH (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (1'b1),
    .in_ready  (fifo_in_ready),
    .in_data   (synced),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (head_bits)
  );

  assign head = head_bits;

  // Falling edge of the shift clock, seen while select is high.
  assign shift_edge = fifo_out_valid && prev_sclk && !head.sclk && head.cs;

  always_ff @(posedge clk)
  begin
    if (rst)
      prev_sclk <= 1'b0;
    else if (fifo_out_valid)
      prev_sclk <= head.sclk;
  end

  // Data is taken from the sample before the fall, the last one of the high phase.
  logic last_data;
  always_ff @(posedge clk)
  begin
    if (rst)
      last_data <= 1'b0;
    else if (fifo_out_valid && head.sclk)
      last_data <= head.data;
  end

  // The stages are cleared by reset so that no unknown reaches the outputs;
  // software must still treat them as meaningless until contents_valid rises.
  always_ff @(posedge clk)
  begin
    if (rst)
      stage_bits <= '0;
    else if (shift_edge)
      stage_bits <= {stage_bits[STAGES-2:0], last_data};
    // Without a shift edge the stages keep their value.
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      fill_count <= '0;
    else if (shift_edge && fill_count != ($clog2(STAGES)+1)'(STAGES))
      fill_count <= fill_count + ($clog2(STAGES)+1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_cs   <= 1'b1;
      cur_gate <= 1'b0;
      cur_inv  <= 1'b0;
    end
    else if (fifo_out_valid)
    begin
      cur_cs   <= head.cs;
      cur_gate <= head.gate;
      cur_inv  <= head.invert;
    end
  end

  // Outputs lag the stages by one cycle, a cost of registering them.
  always_ff @(posedge clk)
  begin
    if (rst)
      drive_out <= '0;
    else if (cur_cs || !cur_gate)
      drive_out <= {STAGES{cur_inv}};
    else
      drive_out <= stage_bits ^ {STAGES{cur_inv}};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_out      <= 1'b0;
      contents_valid  <= 1'b0;
      sample_overflow <= 1'b0;
    end
    else
    begin
      serial_out      <= (fill_count == '0) ? 1'b0 : stage_bits[STAGES-1];
      contents_valid  <= (fill_count == ($clog2(STAGES)+1)'(STAGES));
      sample_overflow <= sample_overflow || !fifo_in_ready;
    end
  end

  AST_BLANK_FORCES_INVERT: assert property (@(posedge clk) disable iff (rst)
    (!cur_gate || cur_cs) |=> drive_out == {STAGES{$past(cur_inv)}})
    else $error("Blanked outputs do not show invert level.");

  AST_DRIVE_FROM_STAGES: assert property (@(posedge clk) disable iff (rst)
    (cur_gate && !cur_cs) |=> drive_out == ($past(stage_bits) ^ {STAGES{$past(cur_inv)}}))
    else $error("Driven outputs do not match stages.");

  AST_HOLD_WHEN_DESELECTED: assert property (@(posedge clk) disable iff (rst)
    (fifo_out_valid && !head.cs) |=> $stable(stage_bits))
    else $error("Stages changed while deselected.");

  AST_SHIFT_ON_FALL: assert property (@(posedge clk) disable iff (rst)
    shift_edge |=> stage_bits[0] == $past(last_data) && stage_bits[STAGES-1:1] == $past(stage_bits[STAGES-2:0]))
    else $error("Shift edge did not move stages.");

  AST_SERIAL_OUT_LAST: assert property (@(posedge clk) disable iff (rst)
    (fill_count != '0) |=> serial_out == $past(stage_bits[STAGES-1]))
    else $error("Serial out does not follow last stage.");

  AST_VALID_AFTER_FILL: assert property (@(posedge clk) disable iff (rst)
    contents_valid |-> $past(fill_count) == ($clog2(STAGES)+1)'(STAGES))
    else $error("Contents flagged valid too early.");

  AST_INVERT_ALL: assert property (@(posedge clk) disable iff (rst)
    (cur_gate && !cur_cs && cur_inv) ##1 (cur_gate && !cur_cs && !cur_inv && $stable(stage_bits))
      |=> drive_out == ~$past(drive_out,1))
    else $error("Invert did not flip every output.");

  AST_NO_SHIFT_WITHOUT_CS: assert property (@(posedge clk) disable iff (rst)
    shift_edge |-> head.cs)
    else $error("Shift without chip select.");
endmodule

//--- test/host_model.sv
// Behavioural host that shifts one 32-bit word into the driver.
`timescale 1ns/10ps
module host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] word,
  // Pins
  output logic             shift_clk,
  output logic             serial_in,
  output logic             chip_select,
  output logic             busy
);
  logic [9:0] step;
  logic [9:0] next_step;
  assign next_step = step + 10'h001;
  // The shift clock idles low, so raising chip select never looks like a fall.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      step <= 10'h000;
      shift_clk <= 1'b0;
      serial_in <= 1'b0;
      chip_select <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      step <= 10'h000;
      chip_select <= 1'b1;
      serial_in <= word[31];
    end
    else if (busy)
    begin
      step <= next_step;
      shift_clk <= (next_step < 10'h200) && next_step[3];
      if (next_step < 10'h200 && next_step[3:0] == 4'h1)
        serial_in <= word[5'h1f - next_step[8:4]];
      if (next_step == 10'h208)
      begin
        busy <= 1'b0;
        chip_select <= 1'b0;
        serial_in <= ~serial_in;
      end
    end
  end
endmodule

//--- test/serial_display_driver_test.sv
// Self-checking bench for the display driver with a second driver cascaded.
`timescale 1ns/10ps
module serial_display_driver_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [31:0] word = 32'h0;
  logic        gate = 1'b1;
  logic        invert = 1'b0;
  logic        extra_clk = 1'b0;
  logic        host_clk, sdata, cs, busy, chain, valid, ovf;
  logic [31:0] out1, out2;
  int          fail_count = 0;
  int          n_compared = 0;
  always #20 clk = ~clk;
  host_model host (.clk(clk), .rst(rst), .start(start), .word(word), .shift_clk(host_clk),
    .serial_in(sdata), .chip_select(cs), .busy(busy));
  serial_display_driver dut (.clk(clk), .rst(rst), .shift_clk(host_clk | extra_clk), .serial_in(sdata),
    .chip_select(cs), .gate(gate), .invert(invert), .drive_out(out1), .serial_out(chain),
    .contents_valid(valid), .sample_overflow(ovf));
  serial_display_driver dut2 (.clk(clk), .rst(rst), .shift_clk(host_clk), .serial_in(chain),
    .chip_select(cs), .gate(gate), .invert(invert), .drive_out(out2), .serial_out(),
    .contents_valid(), .sample_overflow());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic drive_wait(input logic g, input logic inv);
    @(posedge clk);
    gate <= g;
    invert <= inv;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic load(input logic [31:0] w, input logic inv);
    int i;
    @(posedge clk);
    word <= w;
    invert <= inv;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (100) @(negedge clk);
    check(out1, {32{inv}});
    for (i = 0; i < 2000 && busy; i++)
      @(negedge clk);
    if (busy)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic t_show(input logic [31:0] w);
    drive_wait(1'b1, 1'b0);
    check(out1, w);
    check(chain, w[31]);
    check(valid, 1'b1);
    drive_wait(1'b1, 1'b1);
    check(out1, ~w);
    drive_wait(1'b0, 1'b1);
    check(out1, 32'hffffffff);
    drive_wait(1'b1, 1'b0);
    check(out1, w);
  endtask
  task automatic t_hold(input logic [31:0] w);
    repeat (8)
    begin
      @(posedge clk);
      extra_clk <= ~extra_clk;
      repeat (8) @(posedge clk);
    end
    @(negedge clk);
    check(out1, w);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(out1, 32'h0);
    check(valid, 1'b0);
    load(32'ha5c30f96, 1'b0);
    t_show(32'ha5c30f96);
    t_hold(32'ha5c30f96);
    load(32'h3c5ae187, 1'b1);
    t_show(32'h3c5ae187);
    check(out2, 32'ha5c30f96);
    check(ovf, 1'b0);
    stop_test();
  end
endmodule
